// ===== hw/cfs_regs.svh
// Register offsets, field positions, reset values and timing counts of the function select block
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CFS_CTRL_OFF 8'h00
`define CFS_STAT_OFF 8'h04
`define CFS_SMPT_OFF 8'h08
`define CFS_PRESET_OFF 8'h0c
`define CFS_CNT_LO_OFF 8'h10
`define CFS_CNT_HI_OFF 8'h14
`define CFS_LATCH_OFF 8'h18
`define CFS_SAMPLE_OFF 8'h1c
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CFS_CTRL_RUN 0
`define CFS_CTRL_TRIG 1
`define CFS_CTRL_NEGLOGIC 2
`define CFS_CTRL_ZCLR 3
`define CFS_CTRL_MODE_LSB 4
`define CFS_CTRL_ZSET 8
// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define CFS_STAT_SAMPLING 3
`define CFS_STAT_OVF 4
`define CFS_STAT_ZFLAG 5
`define CFS_STAT_HALTED 6
`define CFS_WARN_OVF 16'h0bea
// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define CFS_SMPT_RESET 16'h0001
`define CFS_SMPT_MIN 16'h0001
`define CFS_SMPL_MAX 32'h7fffffff
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CFS_CLK_HZ 200000000
`define CFS_TICK_US 1000
`define CFS_TICK_CYC ((`CFS_CLK_HZ / 1000000) * `CFS_TICK_US)
`define CFS_SMP_STEP_MS 10
`endif

// ===== hw/cfs_pkg.sv
// Types shared by the counter function select block
package cfs_pkg;
    // Selected auxiliary function
    typedef enum logic [1:0] {
        CFS_FN_DISABLE = 2'h0,
        CFS_FN_SAMPLE = 2'h1,
        CFS_FN_DIS_PRESET = 2'h2,
        CFS_FN_LATCH_PRESET = 2'h3
    } cfs_mode_e;
    // Sampling state machine, one-hot
    typedef enum logic [1:0] {
        CFS_SM_IDLE = 2'b01,
        CFS_SM_RUN = 2'b10
    } cfs_smp_e;
    // Classic Wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cfs_wb_req_s;
    // Classic Wishbone answer
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cfs_wb_rsp_s;
endpackage

// ===== hw/cfs_func_select.sv
// Counter function select logic of one pulse counter channel
//
// Behaviour
// - Disable mode: trigger bit halts, release resumes
// - Disable mode: function input halts counting
// - Count only while run request on
// - Run on with trigger on stays halted
// - Sample mode: rising trigger zeroes, starts counting
// - Sampling stops after sampling time
// - Status bit 3 high while sampling
// - Final sample count retained until next run
// - Sampling ignores run request bit
// - Second source on while first on ignored
// - Retrigger zeroes count, timing continues
// - Saturate sample count, raise warning 3050
// - New sampling time applies next run
// - Disable-preset: input rising halts counting
// - Disable-preset: input falling loads preset, resumes
// - Preset write replaces preset setting
// - Run on with input active stays halted
// - Z flag set suppresses preset; host clears
// - Latch-preset: rising latches count, loads preset
// - Latch-preset: run request gates counting
// - Input polarity selectable positive or negative
// - Sampling time in 10ms steps, 10..655350
// - Trigger bit handled on 1ms control cycle
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "cfs_regs.svh"
module cfs_func_select
    import cfs_pkg::*;
#(
    parameter int TICK_CYC = `CFS_TICK_CYC // Cycles per control cycle
)
(
    input wire logic clk_i, // 200 MHz clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire cfs_pkg::cfs_wb_req_s wb_req_i, // Wishbone request
    output cfs_pkg::cfs_wb_rsp_s wb_rsp_o, // Wishbone answer
    input wire logic pulse_i, // Decoded count pulse, same clock
    input wire logic func_pin_i, // Function input pin, asynchronous
    input wire logic zphase_req_i, // Phase Z preset request event
    output logic func_active_o, // Filtered function input, active level
    output logic counting_o, // Count currently advancing
    output logic [15:0] warn_code_o // Channel warning code
);
    import cfs_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchroniser and polarity
    // ----------------------------------------------------------------
    logic [2:0] pin_sync_q; // Three-stage synchroniser
    logic pin_q; // Accepted pin level
    logic neg_logic_q; // Negative logic select
    logic fin_q; // Function input, active level, delayed
    wire fin_raw = pin_q ^ neg_logic_q; // Active level of input
    wire fin_rise = fin_raw & ~fin_q; // Input turned active
    wire fin_fall = ~fin_raw & fin_q; // Input turned inactive

    // Synchronise and accept agreed level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_sync_q <= 3'h0;
            pin_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], func_pin_i};
            if (pin_sync_q[1] == pin_sync_q[2])
                pin_q <= pin_sync_q[2];
        end
    end

    // ----------------------------------------------------------------
    // Control cycle tick
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_q; // Tick divider
    wire tick = (tick_cnt_q == 32'(TICK_CYC - 1)); // One-cycle tick pulse

    // Free-running control cycle divider
    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic run_q; // Count run request
    logic trig_q; // Selected function trigger bit
    logic trig_s_q; // Trigger seen on control cycle
    cfs_mode_e mode_q; // Selected function
    logic [15:0] smpt_q; // Sampling time, 10ms units
    logic [31:0] preset_q; // Preset setting
    logic [31:0] count_q; // Present count value
    logic [31:0] latch_q; // First latch register
    logic [31:0] sample_q; // Sampling count
    logic zflag_q; // Phase Z preset request flag
    logic ovf_q; // Sampling overflow warning
    cfs_smp_e smp_q; // Sampling state
    logic [31:0] smp_left_q; // Remaining sampling ticks
    logic latch_pend_q; // Latch reads zero the cycle after update
    logic ack_q; // Wishbone ack
    logic [31:0] rdat_q; // Read data

    // Trigger bit seen only on the control cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_s_q <= 1'b0;
            fin_q <= 1'b0;
        end
        else
        begin
            fin_q <= fin_raw;
            if (tick)
                trig_s_q <= trig_q;
        end
    end
    wire trig_rise = tick & trig_q & ~trig_s_q; // Trigger rising on tick

    // ----------------------------------------------------------------
    // Function decode
    // ----------------------------------------------------------------
    wire m_dis = (mode_q == CFS_FN_DISABLE);
    wire m_smp = (mode_q == CFS_FN_SAMPLE);
    wire m_dp = (mode_q == CFS_FN_DIS_PRESET);
    wire m_lp = (mode_q == CFS_FN_LATCH_PRESET);
    wire other_on_t = fin_q; // Input already on when trigger rises
    wire other_on_f = trig_s_q; // Trigger already on when input rises
    wire smp_start = m_smp & ((trig_rise & ~other_on_t) | (fin_rise & ~other_on_f));
    wire halt_dis = m_dis & (trig_s_q | fin_q);
    wire halt_dp = m_dp & fin_q;
    wire can_preset = ~zflag_q;
    wire dp_load = m_dp & fin_fall & can_preset;
    wire lp_load = m_lp & fin_rise;
    wire count_en = run_q & ~halt_dis & ~halt_dp & ~m_smp;
    wire smp_run = (smp_q == CFS_SM_RUN);
    wire smp_sat = (sample_q == `CFS_SMPL_MAX);

    // ----------------------------------------------------------------
    // Present count and latch
    // ----------------------------------------------------------------
    // Count, preset load and latch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_q <= 32'h0;
            latch_q <= 32'h0;
            latch_pend_q <= 1'b0;
        end
        else
        begin
            latch_pend_q <= lp_load;
            if (lp_load)
                latch_q <= count_q;
            if (dp_load || (lp_load && can_preset))
                count_q <= preset_q;
            else if (count_en && pulse_i && !fin_fall)
                count_q <= count_q + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Sampling counter
    // ----------------------------------------------------------------
    // Sampling run, window and saturation
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            smp_q <= CFS_SM_IDLE;
            smp_left_q <= 32'h0;
            sample_q <= 32'h0;
            ovf_q <= 1'b0;
        end
        else
        begin
            unique case (smp_q)
                CFS_SM_IDLE:
                begin
                    if (smp_start)
                    begin
                        smp_q <= CFS_SM_RUN;
                        smp_left_q <= 32'(smpt_q) * `CFS_SMP_STEP_MS;
                        sample_q <= 32'h0;
                    end
                end
                CFS_SM_RUN:
                begin
                    if (tick)
                    begin
                        if (smp_left_q == 32'h1)
                            smp_q <= CFS_SM_IDLE;
                        smp_left_q <= smp_left_q - 32'h1;
                    end
                    if (smp_start)
                        sample_q <= 32'h0;
                    else if (pulse_i && !smp_sat)
                        sample_q <= sample_q + 32'h1;
                    else if (pulse_i)
                        ovf_q <= 1'b1;
                end
                default:
                    smp_q <= CFS_SM_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    wire wb_hit = wb_req_i.cyc & wb_req_i.stb & ~ack_q; // New access
    wire wb_wr = wb_hit & wb_req_i.we & wb_req_i.sel[0];
    wire wr_ctrl = wb_wr & (wb_req_i.adr == `CFS_CTRL_OFF);
    wire wr_smpt = wb_wr & (wb_req_i.adr == `CFS_SMPT_OFF);
    wire wr_pre = wb_wr & (wb_req_i.adr == `CFS_PRESET_OFF);
    wire zclr = wr_ctrl & wb_req_i.dat[`CFS_CTRL_ZCLR];
    wire [15:0] stat_w = {9'h0, ~count_en, zflag_q, ovf_q, smp_run, 3'h0};
    logic [31:0] rmux; // Read mux
    always_comb
    begin
        unique case (wb_req_i.adr)
            `CFS_CTRL_OFF: rmux = {23'h0, zflag_q, 2'h0, mode_q, 1'b0,
                neg_logic_q, trig_q, run_q};
            `CFS_STAT_OFF: rmux = {16'h0, stat_w};
            `CFS_SMPT_OFF: rmux = {16'h0, smpt_q};
            `CFS_PRESET_OFF: rmux = preset_q;
            `CFS_CNT_LO_OFF: rmux = {16'h0, count_q[15:0]};
            `CFS_CNT_HI_OFF: rmux = {16'h0, count_q[31:16]};
            `CFS_LATCH_OFF: rmux = latch_pend_q ? 32'h0 : latch_q;
            `CFS_SAMPLE_OFF: rmux = sample_q;
            default: rmux = 32'h0;
        endcase
    end

    // Register writes and answers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            run_q <= 1'b0;
            trig_q <= 1'b0;
            neg_logic_q <= 1'b0;
            mode_q <= CFS_FN_DISABLE;
            smpt_q <= `CFS_SMPT_RESET;
            preset_q <= 32'h0;
            zflag_q <= 1'b0;
        end
        else
        begin
            ack_q <= wb_hit;
            rdat_q <= wb_hit ? rmux : 32'h0;
            if (wr_ctrl)
            begin
                run_q <= wb_req_i.dat[`CFS_CTRL_RUN];
                trig_q <= wb_req_i.dat[`CFS_CTRL_TRIG];
                neg_logic_q <= wb_req_i.dat[`CFS_CTRL_NEGLOGIC];
                mode_q <= cfs_mode_e'(wb_req_i.dat[`CFS_CTRL_MODE_LSB +: 2]);
            end
            if (wr_smpt && wb_req_i.dat[15:0] >= `CFS_SMPT_MIN)
                smpt_q <= wb_req_i.dat[15:0];
            if (wr_pre)
                preset_q <= wb_req_i.dat;
            if (zphase_req_i)
                zflag_q <= 1'b1;
            else if (zclr)
                zflag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};
    assign func_active_o = fin_q;
    assign counting_o = count_en;
    assign warn_code_o = ovf_q ? `CFS_WARN_OVF : 16'h0;
endmodule

// ===== bench/cfs_func_select_chk.sv
// Port assertions of the counter function select block
`timescale 1ns/100ps
`include "cfs_regs.svh"
module cfs_func_select_chk
    import cfs_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset, active high
    input wire cfs_pkg::cfs_wb_req_s wb_req_i, // Bus request
    input wire cfs_pkg::cfs_wb_rsp_s wb_rsp_o, // Bus answer
    input wire logic pulse_i, // Count pulse
    input wire logic func_pin_i, // Function pin
    input wire logic zphase_req_i, // Z request
    input wire logic func_active_o, // Active function input
    input wire logic counting_o, // Count advancing
    input wire logic [15:0] warn_code_o // Warning code
);
    logic [7:0] ctrl_q; // Shadow of the control byte
    wire take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack; // Request taken
    wire ctrl_wr = take && wb_req_i.we && wb_req_i.adr == `CFS_CTRL_OFF && wb_req_i.sel[0];
    wire [1:0] mode = ctrl_q[5:4]; // Shadow mode field
    // Shadow follows control writes at the take edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_q <= 8'h00;
        else if (ctrl_wr)
            ctrl_q <= wb_req_i.dat[7:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (take |=> wb_rsp_o.ack)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
        else $error("read data outside ack");
    AST_RUN_GATE: assert property (counting_o && !wb_rsp_o.ack |-> ctrl_q[0])
        else $error("counting with run off");
    AST_SMP_NOCNT: assert property (counting_o && !wb_rsp_o.ack |-> mode != 2'h1)
        else $error("present count moves in sampling mode");
    AST_DIS_PIN: assert property ((func_active_o[*3] ##0 (mode == 2'h0 && !wb_rsp_o.ack))
        |-> !counting_o)
        else $error("disable mode counts with input active");
    AST_DP_HALT: assert property ((func_active_o[*3] ##0 (mode == 2'h2 && !wb_rsp_o.ack))
        |-> !counting_o)
        else $error("disable preset mode counts with input active");
endmodule

// ===== bench/cfs_field_model.sv
// Field side model: count pulse source of the channel
`timescale 1ns/100ps
module cfs_field_model
(
    input wire logic clk_i, // Clock
    input wire logic en_i, // Pulse train on
    output logic pulse_o // One pulse per cycle while on
);
    // Pulse train follows the enable one cycle later
    always_ff @(posedge clk_i)
    begin
        pulse_o <= en_i;
    end
endmodule

// ===== bench/tb_top.sv
// Top testbench of the counter function select block
`timescale 1ns/100ps
`include "cfs_regs.svh"
module tb_top;
    import cfs_pkg::*;
    localparam int TICK = 20; // Shortened control cycle
    logic clk_i = 1'b0; // Clock
    logic rst_i = 1'b1; // Reset
    cfs_wb_req_s wb_req = '0; // Bus request
    cfs_wb_rsp_s wb_rsp; // Bus answer
    logic pulse_en = 1'b0; // Pulse train on
    logic pulse; // Count pulse
    logic pin = 1'b0; // Function pin
    logic zreq = 1'b0; // Z request
    logic act; // Active input
    logic [15:0] warn; // Warning code
    logic [31:0] rd; // Last read data
    logic [31:0] v0; // Saved value
    int n_errors = 0; // Mismatches
    int checks_done = 0; // Comparisons
    cfs_field_model fld_u (.clk_i(clk_i), .en_i(pulse_en), .pulse_o(pulse));
    cfs_func_select #(.TICK_CYC(TICK)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
        .wb_rsp_o(wb_rsp), .pulse_i(pulse), .func_pin_i(pin), .zphase_req_i(zreq),
        .func_active_o(act), .counting_o(), .warn_code_o(warn));
    // Clock, 5 ns period
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Verdict and end of run
    task automatic conclude();
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Range compare
    task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if (((got >= lo) && (got <= hi)) !== 1'b1)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h", $time, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Classic single cycle, bounded wait for ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        @(posedge clk_i);
        while (wb_rsp.ack !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                n_errors++;
                conclude();
            end
            @(posedge clk_i);
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask
    // Control write, then two control cycles
    task automatic ctl(input logic [31:0] v);
        wb(1'b1, `CFS_CTRL_OFF, v);
        idle(2 * TICK);
    endtask
    task automatic st(input int b, input logic e);
        wb(1'b0, `CFS_STAT_OFF, 0);
        check({31'h0, rd[b]}, {31'h0, e}, {31'h0, e});
    endtask
    // Present count grows by about 23, or stands still
    task automatic grow(input bit yes);
        wb(1'b0, `CFS_CNT_LO_OFF, 0);
        v0 = rd;
        idle(20);
        wb(1'b0, `CFS_CNT_LO_OFF, 0);
        check(rd, yes ? v0 + 20 : v0, yes ? v0 + 30 : v0);
    endtask
    // Count disable mode
    task automatic t_dis();
        ctl(32'h01);
        grow(1);
        pin <= 1'b1;
        idle(10);
        grow(0);
        pin <= 1'b0;
        idle(10);
        grow(1);
        ctl(32'h03);
        grow(0);
        ctl(32'h01);
        grow(1);
        ctl(32'h00);
        grow(0);
        ctl(32'h02);
        grow(0);
        ctl(32'h03);
        grow(0);
        ctl(32'h01);
        grow(1);
    endtask
    // Sampling mode with run off, retrigger and new time
    task automatic t_smp();
        ctl(32'h10);
        pin <= 1'b1;
        idle(10);
        st(`CFS_STAT_SAMPLING, 1'b1);
        idle(100);
        pin <= 1'b0;
        idle(10);
        pin <= 1'b1;
        wb(1'b1, `CFS_SMPT_OFF, 32'h5);
        idle(150);
        st(`CFS_STAT_SAMPLING, 1'b0);
        wb(1'b0, `CFS_SAMPLE_OFF, 0);
        check(rd, 55, 80);
        v0 = rd;
        idle(50);
        wb(1'b0, `CFS_SAMPLE_OFF, 0);
        check(rd, v0, v0);
        pin <= 1'b0;
        idle(10);
        pin <= 1'b1;
        idle(600);
        st(`CFS_STAT_SAMPLING, 1'b1);
        idle(500);
        wb(1'b0, `CFS_SAMPLE_OFF, 0);
        check(rd, 975, 1005);
        pin <= 1'b0;
    endtask
    // Disable with preset
    task automatic t_dp();
        wb(1'b1, `CFS_PRESET_OFF, 32'h1234);
        idle(2 * TICK);
        ctl(32'h21);
        pin <= 1'b1;
        idle(10);
        grow(0);
        ctl(32'h20);
        ctl(32'h21);
        grow(0);
        pin <= 1'b0;
        idle(10);
        wb(1'b0, `CFS_CNT_LO_OFF, 0);
        check(rd, 32'h1234, 32'h1248);
        grow(1);
    endtask
    // Latch with preset, then suppressed preset
    task automatic t_lp();
        ctl(32'h31);
        wb(1'b0, `CFS_CNT_LO_OFF, 0);
        v0 = rd;
        pin <= 1'b1;
        idle(10);
        wb(1'b0, `CFS_LATCH_OFF, 0);
        check(rd, v0, v0 + 20);
        wb(1'b0, `CFS_CNT_LO_OFF, 0);
        check(rd, 32'h1234, 32'h1248);
        pin <= 1'b0;
        ctl(32'h30);
        grow(0);
        ctl(32'h31);
        grow(1);
        zreq <= 1'b1;
        idle(1);
        zreq <= 1'b0;
        st(`CFS_STAT_ZFLAG, 1'b1);
        wb(1'b0, `CFS_CNT_LO_OFF, 0);
        v0 = rd;
        pin <= 1'b1;
        idle(10);
        wb(1'b0, `CFS_CNT_LO_OFF, 0);
        check(rd, v0, v0 + 30);
        pin <= 1'b0;
        ctl(32'h39);
        st(`CFS_STAT_ZFLAG, 1'b0);
    endtask
    // Negative logic input
    task automatic t_pol();
        ctl(32'h05);
        check({31'h0, act}, 1, 1);
        grow(0);
        pin <= 1'b1;
        idle(10);
        grow(1);
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        pulse_en <= 1'b1;
        wb(1'b0, `CFS_SMPT_OFF, 0);
        check(rd, 1, 1);
        wb(1'b0, 8'h20, 0);
        check(rd, 0, 0);
        t_dis();
        t_smp();
        t_dp();
        t_lp();
        t_pol();
        check({16'h0, warn}, 0, 0);
        conclude();
    end
endmodule
bind cfs_func_select cfs_func_select_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pulse_i(pulse_i), .func_pin_i(func_pin_i),
    .zphase_req_i(zphase_req_i), .func_active_o(func_active_o), .counting_o(counting_o),
    .warn_code_o(warn_code_o));
